// ### ocwr_defines.svh
// Purpose: Constants for the overcurrent window and retry block.
// Assumes: Clock of 50 MHz, period 20 ns.
// Notes:   Widths and timing counts live here as macros.
`ifndef OCWR_DEFINES_SVH
`define OCWR_DEFINES_SVH
`define OCWR_CLK_PERIOD_NS   20
`define OCWR_QUANT_STEP_NS   10
`define OCWR_QUANT_STEPS_PER_CLK (`OCWR_CLK_PERIOD_NS / `OCWR_QUANT_STEP_NS)
`define OCWR_CNT_W           16
`define OCWR_LIMIT_W         6
`define OCWR_DAC_W           7
`define OCWR_RETRY_SS_COUNT  4
`define OCWR_SS_CYCLES       340000
`endif

// ### ocwr_pkg.sv
// Purpose: Types for the overcurrent window and retry block.
// Assumes: Widths from ocwr_defines.svh.
// Notes:   All state of the top module except sense_en_out is one packed struct.
`include "ocwr_defines.svh"
package ocwr_pkg;
   typedef enum logic [2:0] {
      OCWR_IDLE,
      OCWR_RUN,
      OCWR_FINISH,
      OCWR_HALF_WAIT,
      OCWR_HALF_PULSE,
      OCWR_RETRY_WAIT
   } ocwr_state_t;

   typedef struct packed {
      logic                      hs_on;
      logic                      ls_on;
   } ocwr_drive_t;

   typedef struct packed {
      ocwr_state_t               state;
      logic [`OCWR_CNT_W-1:0]    on_cnt;
      logic [`OCWR_CNT_W-1:0]    win_len;
      logic [`OCWR_CNT_W-1:0]    win_cnt;
      logic [`OCWR_CNT_W-1:0]    last_on;
      logic [`OCWR_CNT_W-1:0]    half_cnt;
      logic [31:0]               wait_cnt;
      logic [`OCWR_LIMIT_W-1:0]  limit;
      logic [`OCWR_DAC_W-1:0]    dac;
      logic                      fault;
      logic                      trip_prev;
      logic                      hs_prev;
      logic                      retry_req;
      ocwr_drive_t               drive;
   } ocwr_state_s_t;
endpackage

// ### ocwr_sync.sv
// Purpose: Three-stage synchroniser for asynchronous inputs.
// Assumes: One clock, synchronous active-high reset.
// Notes:   A change counts once stages two and three agree.
`timescale 1ns/10ps
module ocwr_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk_in,  // System clock.
   input  wire logic         rst_in,   // Synchronous reset.
   input  wire logic [W-1:0] d_in,     // Asynchronous input.
   output logic      [W-1:0] q_out     // Filtered output.
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   // Shift through three stages and update when the last two agree.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         q_out <= '0;
      end else begin
         s1_r <= d_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
               q_out[i] <= s3_r[i];
            end
         end
      end
   end
endmodule

// ### ocwr_core.sv
// Function
// - Count high-side on-time each cycle in 10 ns steps.
// - Keep three quarters of the count as next cycle's sense window.
// - Sense overcurrent only before the three-quarter point of on-time.
// - A comparator trip inside the active window declares a fault.
// - During soft-start drive twice the stored limit to the converter.
// - After soft-start drive the stored, undoubled limit.
// - After a trip finish the cycle, then one half on-time pulse.
// - Then both drives off, wait four soft-start times, retry.
// - Sensing is active only while the high-side drive is on.
// - Hold a six-bit limit captured at startup and feed the converter.
//
// Purpose: Overcurrent sense window timing and trip shutdown/retry sequence.
// Assumes: mclk_in at 50 MHz; PWM, comparator and soft-start inputs are async.
// Notes:   The shutdown half pulse uses the on-time of the cycle that tripped.
`timescale 1ns/10ps
`include "ocwr_defines.svh"
module ocwr_core #(
   parameter int SS_CYCLES = `OCWR_SS_CYCLES
) (
   input  wire logic                     mclk_in,          // 50 MHz clock.
   input  wire logic                     rst_in,           // Sync reset, active high.
   input  wire logic                     pwm_hs_in,        // PWM high-side request.
   input  wire logic                     pwm_ls_in,        // PWM low-side request.
   input  wire logic                     overcurrent_trip_in, // Comparator above limit.
   input  wire logic                     soft_start_in,    // Soft-start in progress.
   input  wire logic                     limit_capture_in, // Capture limit setting.
   input  wire logic [`OCWR_LIMIT_W-1:0] limit_setting_value_in, // Startup limit code.
   output logic                          hs_drive_out,     // High-side gate drive.
   output logic                          ls_drive_out,     // Low-side gate drive.
   output logic                          sense_en_out,     // Sense window active.
   output logic                          fault_out,        // Overcurrent fault.
   output logic                          retry_start_out,  // Pulse: start soft-start.
   output logic [`OCWR_DAC_W-1:0]        limit_dac_out     // Limit converter code.
);
   localparam logic [31:0] SS_TOTAL = 32'(SS_CYCLES * `OCWR_RETRY_SS_COUNT);

   logic                     hs_s;
   logic                     ls_s;
   logic                     trip_s;
   logic                     ss_s;
   logic                     cap_s;
   ocwr_pkg::ocwr_state_s_t  st_r;
   ocwr_pkg::ocwr_state_s_t  st_nxt;
   logic                     sense_nxt;
   logic                     start_nxt;

   // Bring all pin inputs except the clock, the reset and limit_setting_value_in into the clock domain.
   ocwr_sync #(.W(5)) u_sync (
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .d_in    ({pwm_hs_in, pwm_ls_in, overcurrent_trip_in, soft_start_in,
                 limit_capture_in}),
      .q_out   ({hs_s, ls_s, trip_s, ss_s, cap_s})
   );

   // Three quarters of a count, rounded down.
   function automatic logic [`OCWR_CNT_W-1:0] three_q(input logic [`OCWR_CNT_W-1:0] c);
      logic [`OCWR_CNT_W+1:0] t;
      t = ({2'b00, c} << 1) + {2'b00, c};
      return t[`OCWR_CNT_W+1:2];
   endfunction

   // Next-state logic for the whole block.
   always_comb begin
      st_nxt    = st_r;
      sense_nxt = 1'b0;
      start_nxt = 1'b0;
      st_nxt.trip_prev = trip_s;
      st_nxt.hs_prev   = st_r.drive.hs_on;
      // Limit capture and reference scaling.
      if (cap_s) begin
         st_nxt.limit = limit_setting_value_in;
      end
      st_nxt.dac = ss_s ? {st_r.limit, 1'b0}
                        : {1'b0, st_r.limit};
      case (st_r.state)
         ocwr_pkg::OCWR_IDLE: begin
            st_nxt.drive = '0;
            st_nxt.state = ocwr_pkg::OCWR_RUN;
         end
         ocwr_pkg::OCWR_RUN, ocwr_pkg::OCWR_FINISH: begin
            st_nxt.drive.hs_on = hs_s;
            st_nxt.drive.ls_on = ls_s & ~hs_s;
            if (st_r.drive.hs_on) begin
               // Count on-time; each clock is a whole number of 10 ns steps.
               st_nxt.on_cnt  = st_r.on_cnt
                              + `OCWR_CNT_W'(`OCWR_QUANT_STEPS_PER_CLK);
               st_nxt.win_cnt = st_r.win_cnt
                              + `OCWR_CNT_W'(`OCWR_QUANT_STEPS_PER_CLK);
            end
            // A synced trip counts only while the present sense window is open.
            // The synchroniser adds a few clocks, so a trip late in the window may be missed.
            if (st_r.state == ocwr_pkg::OCWR_RUN && sense_en_out && trip_s) begin
               st_nxt.fault = 1'b1;
               st_nxt.state = ocwr_pkg::OCWR_FINISH;
            end
            // Falling high-side edge closes a cycle.
            if (!st_r.drive.hs_on && st_r.hs_prev) begin
               st_nxt.win_len = three_q(st_r.on_cnt);
               st_nxt.last_on = st_r.on_cnt;
               st_nxt.on_cnt  = '0;
               st_nxt.win_cnt = '0;
               if (st_r.state == ocwr_pkg::OCWR_FINISH) begin
                  st_nxt.drive    = '0;
                  st_nxt.half_cnt = st_r.on_cnt >> 1;
                  st_nxt.state    = ocwr_pkg::OCWR_HALF_PULSE;
               end
            end
            // Open sense for the next clock only if the high side stays on then and that
            // clock ends inside the window, so sense never outlasts the drive.
            sense_nxt = st_nxt.drive.hs_on
                      && ((st_nxt.win_cnt + `OCWR_CNT_W'(`OCWR_QUANT_STEPS_PER_CLK))
                          <= st_nxt.win_len);
         end
         ocwr_pkg::OCWR_HALF_PULSE: begin
            // Trips are ignored here.
            st_nxt.drive.hs_on = 1'b1;
            st_nxt.drive.ls_on = 1'b0;
            // The first clock only raises the drive, so counting starts with it on.
            if (st_r.drive.hs_on || st_r.half_cnt == '0) begin
               if (st_r.half_cnt <= `OCWR_CNT_W'(`OCWR_QUANT_STEPS_PER_CLK)) begin
                  st_nxt.drive    = '0;
                  st_nxt.wait_cnt = SS_TOTAL;
                  st_nxt.state    = ocwr_pkg::OCWR_RETRY_WAIT;
               end else begin
                  st_nxt.half_cnt = st_r.half_cnt
                                  - `OCWR_CNT_W'(`OCWR_QUANT_STEPS_PER_CLK);
               end
            end
         end
         ocwr_pkg::OCWR_RETRY_WAIT: begin
            st_nxt.drive = '0;
            if (st_r.wait_cnt <= 32'h0000_0001) begin
               start_nxt    = 1'b1;
               st_nxt.fault = 1'b0;
               st_nxt.on_cnt  = '0;
               st_nxt.win_cnt = '0;
               st_nxt.win_len = '0;
               st_nxt.state = ocwr_pkg::OCWR_RUN;
            end else begin
               st_nxt.wait_cnt = st_r.wait_cnt - 32'h0000_0001;
            end
         end
         default: begin
            st_nxt.state = ocwr_pkg::OCWR_IDLE;
         end
      endcase
      st_nxt.retry_req = start_nxt;
   end

   // Register all state.
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         st_r         <= '0;
         st_r.state   <= ocwr_pkg::OCWR_IDLE;
         sense_en_out <= 1'b0;
      end else begin
         st_r         <= st_nxt;
         sense_en_out <= sense_nxt;
      end
   end

   // Outputs straight from flip-flops.
   assign hs_drive_out    = st_r.drive.hs_on;
   assign ls_drive_out    = st_r.drive.ls_on;
   assign fault_out       = st_r.fault;
   assign retry_start_out = st_r.retry_req;
   assign limit_dac_out   = st_r.dac;

   // Sense never active without the high-side drive.
   a_sense_needs_hs: assert property (@(posedge mclk_in) disable iff (rst_in)
      sense_en_out |-> hs_drive_out) else $error("sense without hs");

   // Window is three quarters of the previous on-time.
   a_window_three_q: assert property (@(posedge mclk_in) disable iff (rst_in)
      (st_r.state == ocwr_pkg::OCWR_RUN && !st_r.drive.hs_on && st_r.hs_prev) |=>
      st_r.win_len == three_q($past(st_r.on_cnt))) else $error("bad window");

   // Count grows by whole steps while on.
   a_count_step: assert property (@(posedge mclk_in) disable iff (rst_in)
      (st_r.drive.hs_on && st_r.state == ocwr_pkg::OCWR_RUN) |=>
      st_r.on_cnt == $past(st_r.on_cnt) + 16'h0002) else $error("bad count");

   // Sense stays within the window length.
   a_sense_window: assert property (@(posedge mclk_in) disable iff (rst_in)
      sense_en_out |-> st_r.win_cnt <= st_r.win_len) else $error("sense late");

   // Trip in the window sets the fault.
   a_trip_fault: assert property (@(posedge mclk_in) disable iff (rst_in)
      (st_r.state == ocwr_pkg::OCWR_RUN && sense_en_out && trip_s) |=> fault_out)
      else $error("trip lost");

   // Doubled limit during soft-start.
   a_ss_double: assert property (@(posedge mclk_in) disable iff (rst_in)
      ss_s |=> limit_dac_out == {$past(st_r.limit), 1'b0})
      else $error("no double");

   // Plain limit after soft-start.
   a_normal_limit: assert property (@(posedge mclk_in) disable iff (rst_in)
      !ss_s |=> limit_dac_out == {1'b0, $past(st_r.limit)})
      else $error("not plain");

   sequence s_half_done;
      st_r.state == ocwr_pkg::OCWR_HALF_PULSE ##1
      st_r.state == ocwr_pkg::OCWR_RETRY_WAIT;
   endsequence

   // Drives off on the first clock of the retry wait.
   a_retry_off: assert property (@(posedge mclk_in) disable iff (rst_in)
      s_half_done |-> (!hs_drive_out && !ls_drive_out)) else $error("drive on");

   // Half pulse keeps high side on.
   a_half_pulse: assert property (@(posedge mclk_in) disable iff (rst_in)
      (st_r.state == ocwr_pkg::OCWR_HALF_PULSE && $past(st_r.state) ==
      ocwr_pkg::OCWR_HALF_PULSE) |-> hs_drive_out) else $error("half off");

   // Fault holds until the retry start.
   a_fault_hold: assert property (@(posedge mclk_in) disable iff (rst_in)
      (st_r.state == ocwr_pkg::OCWR_RETRY_WAIT && st_nxt.state ==
      ocwr_pkg::OCWR_RETRY_WAIT) |=> fault_out) else $error("fault lost");

   // Captured limit follows the setting.
   a_limit_cap: assert property (@(posedge mclk_in) disable iff (rst_in)
      cap_s |=> st_r.limit == $past(limit_setting_value_in)) else $error("cap");
endmodule

// ### ocwr_partner.sv
// Purpose: Comparator model facing the overcurrent block's drive outputs.
// Assumes: Trip level comes from the bench as an over-limit flag.
// Notes:   The comparator only sees current while the high side conducts.
`timescale 1ns/10ps
module ocwr_partner (
   input  wire logic mclk_in,     // Bench clock.
   input  wire logic hs_drive_in, // High-side gate drive.
   input  wire logic sense_en_in, // Sense window flag.
   input  wire logic over_in,     // Load current above limit.
   input  wire logic late_in,     // Exceed only after the window closes.
   input  wire logic stuck_in,    // Comparator output stuck high.
   output logic      trip_out     // Comparator output.
);
   // The switch voltage reflects current only while the high side is on.
   always @(posedge mclk_in) begin
      trip_out <= stuck_in | (over_in & hs_drive_in & (~late_in | ~sense_en_in));
   end
endmodule

// ### ocwr_core_tb_top.sv
// Purpose: Self-checking bench for the overcurrent window and retry block.
// Assumes: 50 MHz clock, soft-start time shortened to 20 clocks.
// Notes:   On-times are random within 6 to 20 clocks.
`timescale 1ns/10ps
`include "ocwr_defines.svh"
module ocwr_core_tb_top;
   localparam int SS = 20;
   logic                     mclk, rst, pwm_hs, pwm_ls, trip, ss_on, cap;
   logic [`OCWR_LIMIT_W-1:0] lim;
   logic                     hs, ls, sen, fault, retry, over, late, stuck;
   logic [`OCWR_DAC_W-1:0]   dac;
   logic [31:0]              hs_run, hs_len, sen_run, sen_len;
   integer                   seed = 32'h22643d93;
   integer                   mismatches = 0;
   integer                   check_count = 0;
   integer                   n, prev, k, waited;
   logic                     off_ok;
   ocwr_core #(.SS_CYCLES(SS)) ocwr_core_i (
      .mclk_in(mclk), .rst_in(rst), .pwm_hs_in(pwm_hs), .pwm_ls_in(pwm_ls),
      .overcurrent_trip_in(trip), .soft_start_in(ss_on), .limit_capture_in(cap),
      .limit_setting_value_in(lim), .hs_drive_out(hs), .ls_drive_out(ls),
      .sense_en_out(sen), .fault_out(fault), .retry_start_out(retry),
      .limit_dac_out(dac));
   ocwr_partner ocwr_partner_i (.mclk_in(mclk), .hs_drive_in(hs), .sense_en_in(sen),
      .over_in(over), .late_in(late), .stuck_in(stuck), .trip_out(trip));
   // Clock generation.
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // Run lengths of the high-side drive and the sense window.
   always @(posedge mclk) begin
      if (hs === 1'b1) hs_run <= hs_run + 1;
      else if (hs_run != 0) begin
         hs_len <= hs_run;
         hs_run <= 0;
      end
      if (hs === 1'b1 && hs_run == 0) sen_len <= 0;
      if (sen === 1'b1) sen_run <= sen_run + 1;
      else if (sen_run != 0) begin
         sen_len <= sen_run;
         sen_run <= 0;
      end
   end
   // Sense clocks from the prior on-time: two steps a clock, three quarters kept.
   // Sense stops with the drive, so a short cycle cuts the window.
   function automatic int win_clk(input int prev_clk, input int on_clk);
      int w;
      w = ((prev_clk * 2 * 3) / 4) / 2;
      return (w < on_clk) ? w : on_clk;
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count = check_count + 1;
      if (seen !== exp) begin
         mismatches = mismatches + 1;
         $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic conclude;
      if (mismatches == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // One switching cycle of on clocks followed by a low-side interval.
   task automatic cycle(input int on_clk);
      pwm_hs <= 1'b1;
      pwm_ls <= 1'b0;
      repeat (on_clk) @(posedge mclk);
      pwm_hs <= 1'b0;
      pwm_ls <= 1'b1;
      repeat (12) @(posedge mclk);
   endtask
   // Watchdog against a hang.
   initial begin
      #400000;
      mismatches = mismatches + 1;
      conclude();
   end
   initial begin
      {rst, pwm_hs, pwm_ls, ss_on, cap, over, late, stuck} = 8'h80;
      lim = 6'h00;
      hs_run = 0; sen_run = 0; hs_len = 0; sen_len = 0;
      repeat (10) @(posedge mclk);
      rst <= 1'b0;
      repeat (6) @(posedge mclk);
      check("fault_rst", fault, 1'b0);
      // Limit capture and soft-start doubling, with the top code included.
      for (k = 0; k < 3; k++) begin
         cap <= 1'b1;
         lim <= (k == 0) ? 6'h3f : (k == 1) ? 6'h00 : 6'($random(seed));
         repeat (8) @(posedge mclk);
         cap <= 1'b0;
         ss_on <= 1'b1;
         repeat (8) @(posedge mclk);
         check("dac_soft", dac, {lim, 1'b0});
         ss_on <= 1'b0;
         repeat (8) @(posedge mclk);
         check("dac_norm", dac, {1'b0, lim});
      end
      // Random on-times, window taken from the cycle before.
      prev = 0;
      for (k = 0; k < 20; k++) begin
         n = (k == 19) ? 20 : 6 + ($unsigned($random(seed)) % 15);
         cycle(n);
         check("hs_len", hs_len, n);
         check("sen_len", sen_len, win_clk(prev, n));
         check("fault_none", fault, 1'b0);
         prev = n;
      end
      // Over-limit only after the window: no fault; stuck with high side off: no fault.
      over <= 1'b1;
      late <= 1'b1;
      cycle(20);
      check("fault_late", fault, 1'b0);
      over <= 1'b0;
      stuck <= 1'b1;
      repeat (20) @(posedge mclk);
      check("fault_hs_off", fault, 1'b0);
      stuck <= 1'b0;
      late <= 1'b0;
      cycle(20);
      // Trip inside the window, then the half pulse, the off wait and the retry.
      over <= 1'b1;
      pwm_hs <= 1'b1;
      pwm_ls <= 1'b0;
      repeat (20) @(posedge mclk);
      pwm_hs <= 1'b0;
      pwm_ls <= 1'b1;
      check("fault_trip", fault, 1'b1);
      // Let the tripped pulse end, then time the half pulse that follows it.
      waited = 0;
      while (hs_run != 0 && waited < 100) begin
         @(posedge mclk);
         waited++;
      end
      while (hs_run == 0 && waited < 100) begin
         @(posedge mclk);
         waited++;
      end
      stuck <= 1'b1;
      while (hs_run != 0 && waited < 200) begin
         @(posedge mclk);
         waited++;
      end
      @(posedge mclk);
      check("half_len", hs_len, 20 / 2);
      waited = 0;
      off_ok = 1'b1;
      while (retry !== 1'b1 && waited < 200) begin
         @(posedge mclk);
         if (hs !== 1'b0 || ls !== 1'b0) off_ok = 1'b0;
         if (retry !== 1'b1 && fault !== 1'b1) off_ok = 1'b0;
         if (waited == 40) stuck <= 1'b0;
         waited++;
      end
      check("drives_off", off_ok, 1'b1);
      check("retry_wait", (waited >= 4 * SS - 4 && waited <= 4 * SS + 4), 1'b1);
      over <= 1'b0;
      repeat (3) @(posedge mclk);
      check("fault_clear", fault, 1'b0);
      check("retry_pulse", retry, 1'b0);
      cycle(10);
      check("hs_resume", hs_len, 10);
      conclude();
   end
endmodule
